// >>> hw/mhr_consts.vh
`ifndef MHR_CONSTS_VH
`define MHR_CONSTS_VH
// Timing
`define MHR_CLK_NS      20
`define MHR_MS_NS       1000000
`define MHR_CYC_PER_MS  (`MHR_MS_NS / `MHR_CLK_NS)
`define MHR_CLR_MS      10
`define MHR_MS_PER_S    1000
`define MHR_DEC_DIV     33'h0000007D0
// Register byte offsets
`define MHR_A_CTRL      6'h00
`define MHR_A_CFG       6'h04
`define MHR_A_HOME      6'h08
`define MHR_A_HSPD      6'h0C
`define MHR_A_CSPD      6'h10
`define MHR_A_BSPD      6'h14
`define MHR_A_ACC       6'h18
`define MHR_A_DSTOP     6'h1C
`define MHR_A_TRAVEL    6'h20
`define MHR_A_DWELL     6'h24
`define MHR_A_STAT      6'h28
`define MHR_A_POS       6'h2C
// Control bits (write pulses)
`define MHR_C_START     0
`define MHR_C_FAST      1
`define MHR_C_STOP      2
// Configuration fields
`define MHR_F_METH_HI   2
`define MHR_F_METH_LO   0
`define MHR_F_DIR       4
// Status fields
`define MHR_S_DONE      0
`define MHR_S_REQ       1
`define MHR_S_BUSY      2
`define MHR_S_ST_LO     4
// Methods
`define MHR_M_DOG       3'h0
`define MHR_M_STOP1     3'h1
`define MHR_M_STOP2     3'h2
`define MHR_M_STOP3     3'h3
`define MHR_M_CNT1      3'h4
`define MHR_M_CNT2      3'h5
// Ranges and reset values
`define MHR_SPD_MIN     32'h00000001
`define MHR_SPD_MAX     32'h00030D40
`define MHR_RST_SPD     18'h00001
`define MHR_RST_ACC     15'h03E8
`endif

// >>> hw/mhr_sequencer.v
// Operation
// - Dog method: stop at first zero marker after dog goes inactive.
// - Dog methods: on dog active ramp down to creep speed, keep creeping.
// - Stopper one: stop when dwell time from dog active has elapsed.
// - Stopper two: after creep and stopper contact, stop on zero marker.
// - Stopper three: no dog slowdown, creep to stopper, stop on zero.
// - Count one: after travel distance from dog, stop on next zero.
// - Count two: after travel distance, ramp down over stop time, stop.
// - Method selection affects machine return only, not fast return.
// - Start in configured direction: forward increases, reverse decreases.
// - On completion current position takes the home address.
// - Ramp time serves bias-to-home-speed and home-to-creep ramps.
// - Stop cause ramps home speed to bias over the stop time.
// - Fast return decelerates to bias over the stop time.
// - Travel means zero acceptance point or home point, by method.
// - Dwell used by stopper one only; travel by count methods only.
// - After stop pulse deviation clear 10 ms, then set done, clear request.
// - Speeds accepted 1 to 200000, ramp and stop times 0 to 32767 ms; dwell takes the low 16 bits unchecked.
`timescale 1ns/1ps
`default_nettype none
`include "mhr_consts.vh"

module mhr_sequencer #(
  parameter [31:0] CYC_PER_MS = `MHR_CYC_PER_MS,
  parameter [31:0] CLR_CYC    = `MHR_CLR_MS * `MHR_CYC_PER_MS
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [5:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWe,
  input  wire        regRe,
  output wire [31:0] regRdata,
  input  wire        dogIn,
  input  wire        zeroIn,
  input  wire        stopIn,
  input  wire        driveReadyIn,
  output wire        pulseOut,
  output wire        dirOut,
  output wire        devClearOut,
  output wire        busyOut,
  output wire        homeCompleteFlag,
  output wire        homeRequestFlag
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_FAST  = 3'h1;
  localparam [2:0] S_CREEP = 3'h2;
  localparam [2:0] S_ZERO  = 3'h3;
  localparam [2:0] S_HALT  = 3'h4;
  localparam [2:0] S_ABORT = 3'h5;
  localparam [2:0] S_FRET  = 3'h6;
  localparam [2:0] S_CLEAR = 3'h7;

  reg  [2:0]  methQ;
  reg         dirCfgQ;
  reg  [31:0] homeAddrQ;
  reg  [17:0] homeSpdQ;
  reg  [17:0] creepSpdQ;
  reg  [17:0] biasSpdQ;
  reg  [14:0] accTimeQ;
  reg  [14:0] stopTimeQ;
  reg  [31:0] travelQ;
  reg  [15:0] dwellQ;
  reg  [31:0] rdataQ;

  reg  [3:0]  syncAQ;
  reg  [3:0]  syncBQ;
  reg         dogPrevQ;
  reg         zeroPrevQ;
  reg  [15:0] msCntQ;

  reg  [2:0]  stQ;
  reg         dirQ;
  reg         doneQ;
  reg         reqQ;
  reg         decelQ;
  reg  [31:0] posQ;
  reg  [31:0] travelCntQ;
  reg  [15:0] dwellCntQ;
  reg  [31:0] clrCntQ;
  reg  [31:0] accQ;
  reg  [31:0] errQ;
  reg  [17:0] spdQ;
  reg         pulseQ;

  reg  [17:0] spdTgt;
  reg  [17:0] rDelta;
  reg  [14:0] rTime;
  reg  [31:0] rdataD;

  wire        dogS   = syncBQ[0];
  wire        zeroS  = syncBQ[1];
  wire        stopS  = syncBQ[2];
  wire        rdyS   = syncBQ[3];
  wire        zeroRise = zeroS & ~zeroPrevQ;
  wire        msTick = (msCntQ == CYC_PER_MS[15:0] - 16'h0001);

  wire        ctrlWr = regWe & (regAddr == `MHR_A_CTRL);
  wire        startMach = ctrlWr & regWdata[`MHR_C_START];
  wire        startFast = ctrlWr & regWdata[`MHR_C_FAST];
  wire        stopCause = stopS | ~rdyS | (ctrlWr & regWdata[`MHR_C_STOP]);

  wire        moving = (stQ != S_IDLE) && (stQ != S_CLEAR);
  wire [31:0] pulseDen = CYC_PER_MS * `MHR_MS_PER_S;
  wire [31:0] accSum = accQ + {14'h0000, spdQ};
  wire        fire = moving && (accSum >= pulseDen);
  wire [31:0] rampDen = {17'h00000, rTime} * CYC_PER_MS;
  wire [17:0] rStep = (rDelta == 18'h00000) ? 18'h00001 : rDelta;
  wire [31:0] errSum = errQ + {14'h0000, rStep};

  wire [31:0] remain = homeAddrQ - posQ;
  wire [31:0] remainAbs = remain[31] ? (32'h00000000 - remain) : remain;
  wire [32:0] decProd = {15'h0000, spdQ} * {18'h00000, stopTimeQ};
  wire [32:0] decDist = decProd / `MHR_DEC_DIV;

  wire        spdOk = (regWdata >= `MHR_SPD_MIN) &&
                      (regWdata <= `MHR_SPD_MAX);
  wire        timeOk = (regWdata[31:15] == 17'h00000);

  // Register writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      methQ     <= `MHR_M_DOG;
      dirCfgQ   <= 1'b0;
      homeAddrQ <= 32'h00000000;
      homeSpdQ  <= `MHR_RST_SPD;
      creepSpdQ <= `MHR_RST_SPD;
      biasSpdQ  <= `MHR_RST_SPD;
      accTimeQ  <= `MHR_RST_ACC;
      stopTimeQ <= 15'h0000;
      travelQ   <= 32'h00000000;
      dwellQ    <= 16'h0000;
    end else if (regWe) begin
      case (regAddr)
        `MHR_A_CFG: begin
          methQ   <= regWdata[`MHR_F_METH_HI:`MHR_F_METH_LO];
          dirCfgQ <= regWdata[`MHR_F_DIR];
        end
        `MHR_A_HOME:   homeAddrQ <= regWdata;
        `MHR_A_HSPD:   if (spdOk) homeSpdQ <= regWdata[17:0];
        `MHR_A_CSPD:   if (spdOk) creepSpdQ <= regWdata[17:0];
        `MHR_A_BSPD:   if (spdOk) biasSpdQ <= regWdata[17:0];
        `MHR_A_ACC:    if (timeOk) accTimeQ <= regWdata[14:0];
        `MHR_A_DSTOP:  if (timeOk) stopTimeQ <= regWdata[14:0];
        `MHR_A_TRAVEL: if (!regWdata[31]) travelQ <= regWdata;
        `MHR_A_DWELL:  dwellQ <= regWdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux, data stand one cycle after the strobe
  always @* begin
    rdataD = 32'h00000000;
    case (regAddr)
      `MHR_A_CFG: begin
        rdataD[`MHR_F_METH_HI:`MHR_F_METH_LO] = methQ;
        rdataD[`MHR_F_DIR] = dirCfgQ;
      end
      `MHR_A_HOME:   rdataD = homeAddrQ;
      `MHR_A_HSPD:   rdataD[17:0] = homeSpdQ;
      `MHR_A_CSPD:   rdataD[17:0] = creepSpdQ;
      `MHR_A_BSPD:   rdataD[17:0] = biasSpdQ;
      `MHR_A_ACC:    rdataD[14:0] = accTimeQ;
      `MHR_A_DSTOP:  rdataD[14:0] = stopTimeQ;
      `MHR_A_TRAVEL: rdataD = travelQ;
      `MHR_A_DWELL:  rdataD[15:0] = dwellQ;
      `MHR_A_STAT: begin
        rdataD[`MHR_S_DONE] = doneQ;
        rdataD[`MHR_S_REQ]  = reqQ;
        rdataD[`MHR_S_BUSY] = (stQ != S_IDLE);
        rdataD[`MHR_S_ST_LO+2:`MHR_S_ST_LO] = stQ;
      end
      `MHR_A_POS:    rdataD = posQ;
      default:       rdataD = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdataQ <= 32'h00000000;
    end else begin
      rdataQ <= regRe ? rdataD : 32'h00000000;
    end
  end

  // Pin synchronisers and ms divider
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncAQ    <= 4'h0;
      syncBQ    <= 4'h0;
      dogPrevQ  <= 1'b0;
      zeroPrevQ <= 1'b0;
      msCntQ    <= 16'h0000;
    end else begin
      syncAQ    <= {driveReadyIn, stopIn, zeroIn, dogIn};
      syncBQ    <= syncAQ;
      dogPrevQ  <= dogS;
      zeroPrevQ <= zeroS;
      msCntQ    <= msTick ? 16'h0000 : msCntQ + 16'h0001;
    end
  end

  // Ramp target, span and time per state
  always @* begin
    spdTgt = biasSpdQ;
    rDelta = 18'h00000;
    rTime  = accTimeQ;
    case (stQ)
      S_FAST: begin
        if (methQ == `MHR_M_STOP3) begin
          spdTgt = creepSpdQ;
          rDelta = creepSpdQ - biasSpdQ;
        end else begin
          spdTgt = homeSpdQ;
          rDelta = homeSpdQ - biasSpdQ;
        end
      end
      S_CREEP, S_ZERO: begin
        spdTgt = creepSpdQ;
        rDelta = homeSpdQ - creepSpdQ;
      end
      S_HALT: begin
        spdTgt = biasSpdQ;
        rDelta = creepSpdQ - biasSpdQ;
        rTime  = stopTimeQ;
      end
      S_ABORT: begin
        spdTgt = biasSpdQ;
        rDelta = homeSpdQ - biasSpdQ;
        rTime  = stopTimeQ;
      end
      S_FRET: begin
        spdTgt = decelQ ? biasSpdQ : homeSpdQ;
        rDelta = homeSpdQ - biasSpdQ;
        rTime  = decelQ ? stopTimeQ : accTimeQ;
      end
      default: begin
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spdQ   <= 18'h00000;
      errQ   <= 32'h00000000;
      accQ   <= 32'h00000000;
      pulseQ <= 1'b0;
    end else begin
      pulseQ <= fire;
      if (!moving) begin
        spdQ <= biasSpdQ;
        errQ <= 32'h00000000;
        accQ <= 32'h00000000;
      end else begin
        accQ <= fire ? accSum - pulseDen : accSum;
        if (spdQ == spdTgt) begin
          errQ <= 32'h00000000;
        end else if (rTime == 15'h0000) begin
          spdQ <= spdTgt;
          errQ <= 32'h00000000;
        end else if (errSum >= rampDen) begin
          spdQ <= (spdTgt > spdQ) ? spdQ + 18'h00001
                                  : spdQ - 18'h00001;
          errQ <= errSum - rampDen;
        end else begin
          errQ <= errSum;
        end
      end
    end
  end

  // Sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stQ        <= S_IDLE;
      dirQ       <= 1'b0;
      doneQ      <= 1'b0;
      reqQ       <= 1'b1;
      decelQ     <= 1'b0;
      posQ       <= 32'h00000000;
      travelCntQ <= 32'h00000000;
      dwellCntQ  <= 16'h0000;
      clrCntQ    <= 32'h00000000;
    end else begin
      if (fire) begin
        posQ <= dirQ ? posQ - 32'h00000001 : posQ + 32'h00000001;
      end
      case (stQ)
        S_IDLE: begin
          clrCntQ <= 32'h00000000;
          if (startMach && methQ <= `MHR_M_CNT2 && rdyS) begin
            dirQ       <= dirCfgQ;
            doneQ      <= 1'b0;
            reqQ       <= 1'b1;
            travelCntQ <= 32'h00000000;
            dwellCntQ  <= 16'h0000;
            stQ        <= S_FAST;
          end else if (startFast && doneQ && rdyS &&
                       remain != 32'h00000000) begin
            dirQ   <= remain[31];
            decelQ <= 1'b0;
            stQ    <= S_FRET;
          end
        end
        S_FAST: begin
          if (stopCause) begin
            stQ <= S_ABORT;
          end else if (methQ == `MHR_M_STOP3) begin
            // Creep to stopper, stop on zero
            if (zeroRise) begin
              stQ <= S_CLEAR;
            end
          end else if (dogS && !dogPrevQ) begin
            stQ <= S_CREEP;
          end
        end
        S_CREEP: begin
          if (fire) begin
            travelCntQ <= travelCntQ + 32'h00000001;
          end
          if (msTick && dwellCntQ != 16'hFFFF) begin
            dwellCntQ <= dwellCntQ + 16'h0001;
          end
          if (stopCause) begin
            stQ <= S_ABORT;
          end else begin
            case (methQ)
              `MHR_M_DOG: begin
                if (!dogS) begin
                  stQ <= S_ZERO;
                end
              end
              `MHR_M_STOP1: begin
                if (dwellCntQ >= dwellQ) begin
                  stQ <= S_CLEAR;
                end
              end
              `MHR_M_STOP2: begin
                if (zeroRise) begin
                  stQ <= S_CLEAR;
                end
              end
              `MHR_M_CNT1: begin
                if (travelCntQ >= travelQ) begin
                  stQ <= S_ZERO;
                end
              end
              `MHR_M_CNT2: begin
                if (travelCntQ >= travelQ) begin
                  stQ <= S_HALT;
                end
              end
              default: stQ <= S_ABORT;
            endcase
          end
        end
        S_ZERO: begin
          if (stopCause) begin
            stQ <= S_ABORT;
          end else if (zeroRise) begin
            stQ <= S_CLEAR;
          end
        end
        S_HALT: begin
          if (spdQ == biasSpdQ) begin
            stQ <= S_CLEAR;
          end
        end
        S_ABORT: begin
          if (spdQ == biasSpdQ) begin
            stQ <= S_IDLE;
          end
        end
        S_FRET: begin
          if (remain == 32'h00000000) begin
            stQ <= S_IDLE;
          end else if (stopCause) begin
            stQ <= S_ABORT;
          end else if ({1'b0, remainAbs} <= decDist) begin
            decelQ <= 1'b1;
          end
        end
        S_CLEAR: begin
          clrCntQ <= clrCntQ + 32'h00000001;
          if (clrCntQ == CLR_CYC - 32'h00000001) begin
            doneQ <= 1'b1;
            reqQ  <= 1'b0;
            posQ  <= homeAddrQ;
            stQ   <= S_IDLE;
          end
        end
        default: stQ <= S_IDLE;
      endcase
    end
  end

  assign regRdata         = rdataQ;
  assign pulseOut         = pulseQ;
  assign dirOut           = dirQ;
  assign devClearOut      = (stQ == S_CLEAR);
  assign busyOut          = (stQ != S_IDLE);
  assign homeCompleteFlag = doneQ;
  assign homeRequestFlag  = reqQ;

endmodule // mhr_sequencer
`default_nettype wire

// >>> verification/mhr_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module mhr_drive_model #(
  parameter int DOG_LO   = 20,
  parameter int DOG_HI   = 40,
  parameter int ZERO_PER = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pulseOut,
  input  wire logic        dirOut,
  input  wire logic        rezero,
  output var  logic        dogIn,
  output var  logic        zeroIn,
  output var  logic [31:0] pos_q
);
  logic [31:0] mag;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pos_q <= 32'h00000000;
    else if (rezero)
      pos_q <= 32'h00000000;
    else if (pulseOut)
      pos_q <= dirOut ? pos_q - 32'h00000001 : pos_q + 32'h00000001;
  end
  // Dog band and marker by distance from the start point, either way
  always_comb begin
    mag = pos_q[31] ? -pos_q : pos_q;
    dogIn = mag >= DOG_LO && mag <= DOG_HI;
    zeroIn = mag % ZERO_PER == 0;
  end
endmodule // mhr_drive_model
`default_nettype wire

// >>> verification/mhr_seq_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mhr_seq_checker #(
  parameter [31:0] CLR_CYC = 32'h00000014
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pulseOut,
  input wire logic dirOut,
  input wire logic devClearOut,
  input wire logic busyOut,
  input wire logic homeCompleteFlag,
  input wire logic homeRequestFlag
);
  logic [31:0] clrCnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Length of the current deviation-clear pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      clrCnt_q <= 32'h00000000;
    else if (devClearOut)
      clrCnt_q <= clrCnt_q + 32'h00000001;
    else
      clrCnt_q <= 32'h00000000;
  end
  property p_clrLen;
    $fell(devClearOut) |-> clrCnt_q == CLR_CYC;
  endproperty
  a_clrLen: assert property (p_clrLen) else $error("clear length");
  property p_clrMin;
    $rose(devClearOut) |-> devClearOut[*8];
  endproperty
  a_clrMin: assert property (p_clrMin) else $error("clear short");
  property p_doneAfterClr;
    $fell(devClearOut) |-> homeCompleteFlag && !homeRequestFlag;
  endproperty
  a_doneAfterClr: assert property (p_doneAfterClr) else $error("flags");
  property p_doneCause;
    $rose(homeCompleteFlag) |-> $past(devClearOut);
  endproperty
  a_doneCause: assert property (p_doneCause) else $error("early done");
  property p_reqCause;
    $fell(homeRequestFlag) |-> $past(devClearOut);
  endproperty
  a_reqCause: assert property (p_reqCause) else $error("early req");
  property p_clrQuiet;
    devClearOut && $past(devClearOut) |-> !pulseOut;
  endproperty
  a_clrQuiet: assert property (p_clrQuiet) else $error("pulse in clear");
  property p_dirHold;
    busyOut && $past(busyOut) |-> $stable(dirOut);
  endproperty
  a_dirHold: assert property (p_dirHold) else $error("dir moved");
  property p_idleQuiet;
    !busyOut && !$past(busyOut) |-> !pulseOut;
  endproperty
  a_idleQuiet: assert property (p_idleQuiet) else $error("idle pulse");
endmodule // mhr_seq_checker
`default_nettype wire

// >>> verification/mhr_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mhr_consts.vh"
module mhr_sequencer_tb;
  localparam [31:0] CLR_CYC = 32'h00000014;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  regAddr = 6'h00;
  logic [31:0] regWdata = 32'h00000000;
  logic        regWe = 1'b0;
  logic        regRe = 1'b0;
  logic        stopIn = 1'b0;
  logic        driveReadyIn = 1'b1;
  logic        rezero = 1'b0;
  wire  [31:0] regRdata;
  wire  [31:0] mPos;
  wire         pulseOut, dirOut, devClearOut, busyOut, dogIn, zeroIn;
  wire         homeCompleteFlag, homeRequestFlag;
  int          mismatches = 0;
  int          totalChecks = 0;
  always #10 clk = ~clk;
  mhr_sequencer #(.CYC_PER_MS(32'h00000032), .CLR_CYC(CLR_CYC)) DUT (
    .clk, .rst_n, .regAddr, .regWdata, .regWe, .regRe, .regRdata,
    .dogIn, .zeroIn, .stopIn, .driveReadyIn, .pulseOut, .dirOut,
    .devClearOut, .busyOut, .homeCompleteFlag, .homeRequestFlag);
  mhr_drive_model MDL (.clk, .rst_n, .pulseOut, .dirOut, .rezero,
    .dogIn, .zeroIn, .pos_q(mPos));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    regWe <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWe <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    regRe <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRe <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busyOut !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    // A run that never settles counts as a mismatch
    chk({31'h00000000, busyOut}, 32'h00000000);
  endtask
  task automatic t_regs;
    logic [31:0] r;
    rd(`MHR_A_STAT, r);
    chk(r, 32'h00000002);
    rd(`MHR_A_ACC, r);
    chk(r, 32'h000003E8);
    wr(`MHR_A_HSPD, 32'h00030D40);
    rd(`MHR_A_HSPD, r);
    chk(r, 32'h00030D40);
    wr(`MHR_A_HSPD, 32'h00030D41);
    wr(`MHR_A_ACC, 32'h00008000);
    rd(`MHR_A_HSPD, r);
    chk(r, 32'h00030D40);
    rd(`MHR_A_ACC, r);
    chk(r, 32'h000003E8);
    rd(6'h30, r);
    chk(r, 32'h00000000);
    wr(`MHR_A_HSPD, 32'h00001388);
    wr(`MHR_A_CSPD, 32'h000003E8);
    wr(`MHR_A_BSPD, 32'h000003E8);
    wr(`MHR_A_ACC, 32'h00000000);
    wr(`MHR_A_TRAVEL, 32'h0000000F);
    wr(`MHR_A_DWELL, 32'h00000002);
  endtask
  task automatic run_home(input logic [2:0] m, input logic dir,
                          input logic [31:0] h, input int e, input int tol);
    logic [31:0] r;
    int          dv;
    wr(`MHR_A_CFG, {27'h0000000, dir, 1'b0, m});
    wr(`MHR_A_HOME, h);
    rezero <= 1'b1;
    @(posedge clk);
    rezero <= 1'b0;
    wr(`MHR_A_CTRL, 32'h00000001);
    repeat (4) @(posedge clk);
    chk({31'h00000000, dirOut}, {31'h00000000, dir});
    chk({31'h00000000, homeRequestFlag}, 32'h00000001);
    wait_idle();
    chk({30'h00000000, homeCompleteFlag, homeRequestFlag}, 32'h2);
    rd(`MHR_A_POS, r);
    chk(r, h);
    dv = $signed(mPos) - e;
    chk({31'h0, (dv <= tol && dv >= -tol)}, 32'h1);
  endtask
  task automatic t_methods;
    run_home(`MHR_M_DOG, 1'b0, 32'h00000100, 48, 0);
    run_home(`MHR_M_STOP1, 1'b0, 32'h00000200, 22, 2);
    run_home(`MHR_M_STOP2, 1'b0, 32'h00000300, 32, 0);
    run_home(`MHR_M_STOP3, 1'b0, 32'h00000400, 16, 0);
    run_home(`MHR_M_CNT1, 1'b0, 32'h00000500, 48, 0);
    run_home(`MHR_M_CNT2, 1'b0, 32'h00000600, 35, 1);
    run_home(`MHR_M_DOG, 1'b1, 32'hFFFFFF00, -48, 0);
  endtask
  task automatic t_refused;
    logic [31:0] r;
    // Fast return at the home point has nowhere to go
    wr(`MHR_A_CTRL, 32'h00000002);
    repeat (2) @(posedge clk);
    chk({31'h00000000, busyOut}, 32'h00000000);
    // Method code outside the six is refused
    wr(`MHR_A_CFG, 32'h00000006);
    wr(`MHR_A_CTRL, 32'h00000001);
    repeat (2) @(posedge clk);
    rd(`MHR_A_STAT, r);
    chk(r, 32'h00000001);
  endtask
  task automatic t_stop_causes;
    logic [31:0] h0, r;
    int          c, n;
    for (c = 0; c < 3; c++) begin
      rd(`MHR_A_POS, h0);
      wr(`MHR_A_CFG, 32'h00000000);
      rezero <= 1'b1;
      @(posedge clk);
      rezero <= 1'b0;
      wr(`MHR_A_CTRL, 32'h00000001);
      n = 0;
      while (mPos < 32'h00000005 && n < 1000) begin
        @(posedge clk);
        n++;
      end
      chk({31'h00000000, (mPos >= 32'h00000005)}, 32'h00000001);
      if (c == 0)
        driveReadyIn <= 1'b0;
      else if (c == 1)
        stopIn <= 1'b1;
      else
        wr(`MHR_A_CTRL, 32'h00000004);
      wait_idle();
      driveReadyIn <= 1'b1;
      stopIn <= 1'b0;
      repeat (3) @(posedge clk);
      chk({30'h0, homeCompleteFlag, homeRequestFlag}, 32'h1);
      rd(`MHR_A_POS, r);
      chk(r, h0 + mPos);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_methods();
    t_refused();
    t_stop_causes();
    complete_run();
  end
  initial begin
    #1600000;
    mismatches++;
    complete_run();
  end
endmodule // mhr_sequencer_tb
bind mhr_sequencer mhr_seq_checker #(.CLR_CYC(CLR_CYC)) u_chk (
  .clk, .rst_n, .pulseOut, .dirOut, .devClearOut, .busyOut,
  .homeCompleteFlag, .homeRequestFlag);
`default_nettype wire
